/* File: rtl/cvc_params.svh */
// constants of the codec control register bank: offsets, field positions, reset values
// assumes inclusion by cvc_pkg and cvc_regs only
`ifndef CVC_PARAMS_SVH
`define CVC_PARAMS_SVH
// =============================================
// register addresses
`define CVC_ADR_STATUS      8'h80
`define CVC_ADR_IRQ_EN      8'h81
`define CVC_ADR_DEC_VAD_LVL 8'hd4
`define CVC_ADR_DEC_PCM_OUT 8'hd6
`define CVC_ADR_DEC_ADM_OUT 8'hda
`define CVC_ADR_ENC_MODE    8'he0
`define CVC_ADR_ENC_VAD_THR 8'he2
`define CVC_ADR_ENC_OFFS    8'he3
`define CVC_ADR_ENC_OFFS_EST 8'he5
`define CVC_ADR_ENC_PCM_OUT 8'he6
`define CVC_ADR_ENC_DAC     8'he7
`define CVC_ADR_ENC_ADM_TST 8'he8
`define CVC_ADR_ENC_ADM_OUT 8'hea
// =============================================
// encoder mode fields
`define CVC_MODE_OFFS_EN  8
`define CVC_MODE_TC_HI    4
`define CVC_MODE_TC_LO    3
`define CVC_MODE_ZERO_HI  2
`define CVC_MODE_ZERO_LO  1
`define CVC_MODE_HALF_Z   0
// =============================================
// status bit positions
`define CVC_ST_ENC_VAD 6
`define CVC_ST_ENC_PCM 5
`define CVC_ST_ENC_ADM 4
`define CVC_ST_DEC_VAD 2
`define CVC_ST_DEC_PCM 1
`define CVC_ST_DEC_ADM 0
// =============================================
// reset values and limits
`define CVC_RST_WORD   16'h0000
`define CVC_RST_BYTE   8'h00
`define CVC_THR_MASK   16'h7fff
`define CVC_BITS_BYTE  3'h7
`endif

/* File: rtl/cvc_pkg.sv */
// types shared by the codec control register bank
// assumes cvc_params.svh on the include path
package cvc_pkg;
`include "cvc_params.svh"
   typedef enum logic {SB_IDLE, SB_SHIFT} cvc_sb_state_t;
   typedef enum logic [1:0] {XF_IDLE, XF_WR_HI, XF_WR_LO, XF_RD} cvc_xf_state_t;
   typedef struct packed {
      logic       offs_en;
      logic [1:0] est_tc;
      logic [1:0] zero_sel;
      logic       half_zero;
   } cvc_mode_t;
   typedef struct packed {
      logic       first_order;
      logic [1:0] loss_shift;
      logic [1:0] zero_sel;
      logic       half_zero_en;
   } cvc_est_cfg_t;
   typedef struct packed {
      logic enc_pcm;
      logic enc_adm;
      logic dec_pcm;
      logic dec_adm;
   } cvc_evt_t;
endpackage

/* File: rtl/cvc_regs.sv */
// codec control and status register bank behind the serial control port
// assumes codec core signals share sys_clk; serial pins are asynchronous
module cvc_regs
   import cvc_pkg::*;
(
   input  wire logic        sys_clk,       // 40 MHz system clock
   input  wire logic        sys_rst,       // async reset, high
   input  wire logic        clk_en,        // freezes state when low
   input  wire logic        sbus_csn_n,    // serial select, low active
   input  wire logic        sbus_sclk,     // host serial clock
   input  wire logic        sbus_din,      // command/data in
   output logic             sbus_dout,     // reply data out
   output logic             sbus_dout_oe,  // reply drive enable
   output logic             irq_n_ff,      // interrupt request, low active
   input  wire logic        enc_vad,       // encoder voice detected
   input  wire logic        dec_vad,       // decoder voice detected
   input  wire logic [15:0] dec_vad_level, // decoder envelope, non-positive
   input  cvc_evt_t         core_evt,      // data available/needed pulses
   input  wire logic        dec_adm_mode,  // decoder decodes adm
   input  wire logic [15:0] enc_sample,    // encoder input sample
   input  wire logic        enc_sample_vld,// sample strobe
   output logic [15:0]      enc_adj_ff,    // sample plus offset
   output logic             enc_adj_vld_ff,// adjusted sample strobe
   output cvc_est_cfg_t     est_cfg_ff,    // estimator configuration
   output logic [15:0]      vad_thr_ff,    // encoder voice threshold
   output logic [15:0]      dac_direct_ff, // direct dac word
   output logic             dac_load_ff,   // dac word written pulse
   output logic [7:0]       adm_test_ff,   // host adm bits
   output logic             adm_test_vld_ff// adm bits written pulse
);
   // =============================================
   // decode functions
   function automatic logic is_wide_wr(input logic [7:0] a);
      if (a == `CVC_ADR_ENC_MODE)
         is_wide_wr = 1'b1;
      else if (a == `CVC_ADR_ENC_VAD_THR)
         is_wide_wr = 1'b1;
      else if (a == `CVC_ADR_ENC_OFFS)
         is_wide_wr = 1'b1;
      else if (a == `CVC_ADR_ENC_DAC)
         is_wide_wr = 1'b1;
      else
         is_wide_wr = 1'b0;
   endfunction

   function automatic logic is_byte_wr(input logic [7:0] a);
      if (a == `CVC_ADR_IRQ_EN)
         is_byte_wr = 1'b1;
      else if (a == `CVC_ADR_ENC_ADM_TST)
         is_byte_wr = 1'b1;
      else
         is_byte_wr = 1'b0;
   endfunction

   // clear mask {enc_pcm, enc_adm, dec_pcm, dec_adm} for reads that service a flag
   function automatic logic [3:0] svc_mask(input logic [7:0] a);
      if (a == `CVC_ADR_ENC_PCM_OUT)
         svc_mask = 4'b1000;
      else if (a == `CVC_ADR_ENC_ADM_OUT)
         svc_mask = 4'b0100;
      else if (a == `CVC_ADR_DEC_PCM_OUT)
         svc_mask = 4'b0010;
      else if (a == `CVC_ADR_DEC_ADM_OUT)
         svc_mask = 4'b0001;
      else
         svc_mask = 4'b0000;
   endfunction

   // =============================================
   // serial port
   logic          rx_vld;
   logic [7:0]    rx_byte;
   logic [1:0]    rx_idx;
   logic          sb_act;
   logic          tx_load;
   logic [15:0]   tx_word;

   cvc_sbus u_sbus (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .csn_n_pin  (sbus_csn_n),
      .sclk_pin   (sbus_sclk),
      .din_pin    (sbus_din),
      .tx_load    (tx_load),
      .tx_word    (tx_word),
      .rx_vld_ff  (rx_vld),
      .rx_byte_ff (rx_byte),
      .rx_idx_ff  (rx_idx),
      .act_ff     (sb_act),
      .dout_ff    (sbus_dout),
      .dout_oe_ff (sbus_dout_oe)
   );

   // =============================================
   // registers and state
   cvc_xf_state_t xf_ff, nxt_xf;
   logic [7:0]    addr_ff;
   logic [7:0]    hi_ff;
   cvc_mode_t     mode_ff;
   logic [7:0]    irq_en_ff;
   logic [15:0]   offs_in_ff;
   logic [15:0]   offs_est_ff;
   logic [3:0]    flags_ff;
   logic          enc_vad_ff;
   logic          dec_vad_ff;
   logic          irq_pend_ff;

   // =============================================
   // transfer decode
   wire           addr_vld = rx_vld && (rx_idx == 2'h0);
   wire           wr_stb   = rx_vld && (xf_ff == XF_WR_LO);
   wire [15:0]    wr_data  = is_wide_wr(addr_ff) ? {hi_ff, rx_byte} : {8'h00, rx_byte};
   wire           wr_mode  = wr_stb && (addr_ff == `CVC_ADR_ENC_MODE);
   wire           wr_thr   = wr_stb && (addr_ff == `CVC_ADR_ENC_VAD_THR);
   wire           wr_offs  = wr_stb && (addr_ff == `CVC_ADR_ENC_OFFS);
   wire           wr_dac   = wr_stb && (addr_ff == `CVC_ADR_ENC_DAC);
   wire           wr_admt  = wr_stb && (addr_ff == `CVC_ADR_ENC_ADM_TST);
   wire           wr_irqen = wr_stb && (addr_ff == `CVC_ADR_IRQ_EN);
   wire           rd_stat  = addr_vld && (rx_byte == `CVC_ADR_STATUS);

   // status byte; bits 7 and 3 are wired low
   wire [7:0]     status   = {1'b0, enc_vad_ff, flags_ff[3:2],
                              1'b0, dec_vad_ff, flags_ff[1:0]};

   // any address outside the write set loads a reply; unmapped ones reply zero
   wire           is_rd    = !is_wide_wr(rx_byte) && !is_byte_wr(rx_byte);
   assign tx_load = addr_vld && is_rd;
   assign tx_word = (rx_byte == `CVC_ADR_STATUS)       ? {status, 8'h00} :
                    (rx_byte == `CVC_ADR_DEC_VAD_LVL)  ? dec_vad_level   :
                    (rx_byte == `CVC_ADR_ENC_OFFS_EST) ? offs_est_ff     :
                    `CVC_RST_WORD;

   always_comb
   begin
      nxt_xf = xf_ff;
      if (!sb_act)
         nxt_xf = XF_IDLE;
      else if (addr_vld)
      begin
         if (is_wide_wr(rx_byte))
            nxt_xf = XF_WR_HI;
         else if (is_byte_wr(rx_byte))
            nxt_xf = XF_WR_LO;
         else
            nxt_xf = XF_RD;
      end
      else if (rx_vld)
      begin
         case (xf_ff)
            XF_WR_HI: nxt_xf = XF_WR_LO;
            XF_WR_LO: nxt_xf = XF_IDLE;
            default:  nxt_xf = xf_ff;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         xf_ff   <= XF_IDLE;
         addr_ff <= `CVC_RST_BYTE;
         hi_ff   <= `CVC_RST_BYTE;
      end
      else if (clk_en)
      begin
         xf_ff <= nxt_xf;
         if (addr_vld)
            addr_ff <= rx_byte;
         if (rx_vld && (xf_ff == XF_WR_HI))
            hi_ff <= rx_byte;
      end
   end

   // =============================================
   // write registers
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode_ff         <= '0;
         irq_en_ff       <= `CVC_RST_BYTE;
         vad_thr_ff      <= `CVC_RST_WORD;
         offs_in_ff      <= `CVC_RST_WORD;
         dac_direct_ff   <= `CVC_RST_WORD;
         dac_load_ff     <= 1'b0;
         adm_test_ff     <= `CVC_RST_BYTE;
         adm_test_vld_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         dac_load_ff     <= wr_dac;
         adm_test_vld_ff <= wr_admt;
         if (wr_mode)
         begin
            mode_ff.offs_en   <= wr_data[`CVC_MODE_OFFS_EN];
            mode_ff.est_tc    <= wr_data[`CVC_MODE_TC_HI:`CVC_MODE_TC_LO];
            mode_ff.zero_sel  <= wr_data[`CVC_MODE_ZERO_HI:`CVC_MODE_ZERO_LO];
            mode_ff.half_zero <= wr_data[`CVC_MODE_HALF_Z];
         end
         if (wr_irqen)
            irq_en_ff <= wr_data[7:0];
         // top bit dropped: threshold is unsigned 15-bit
         if (wr_thr)
            vad_thr_ff <= wr_data & `CVC_THR_MASK;
         if (wr_offs)
            offs_in_ff <= wr_data;
         if (wr_dac)
            dac_direct_ff <= wr_data;
         if (wr_admt)
            adm_test_ff <= wr_data[7:0];
      end
   end

   // =============================================
   // estimator configuration seen by the codec core
   wire           first_ord = (mode_ff.est_tc == 2'b00);

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         est_cfg_ff <= '0;
      else if (clk_en)
      begin
         est_cfg_ff.first_order  <= first_ord;
         est_cfg_ff.loss_shift   <= mode_ff.est_tc;
         est_cfg_ff.zero_sel     <= first_ord ? 2'b00 : mode_ff.zero_sel;
         // bit is honoured only on the adm decode path; the host guards encode
         est_cfg_ff.half_zero_en <= mode_ff.half_zero && dec_adm_mode;
      end
   end

   // =============================================
   // offset compensation
   // tracking steps by the programmed constant against the sign of the
   // last adjusted sample; the estimate wraps rather than saturates
   wire           trk_on   = mode_ff.offs_en && (offs_in_ff != `CVC_RST_WORD);
   wire [15:0]    trk_step = enc_adj_ff[15] ? 16'(offs_est_ff + offs_in_ff)
                                            : 16'(offs_est_ff - offs_in_ff);
   wire [15:0]    nxt_offs_est = !mode_ff.offs_en ? offs_in_ff :
                                 (trk_on && enc_sample_vld) ? trk_step :
                                 offs_est_ff;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         offs_est_ff    <= `CVC_RST_WORD;
         enc_adj_ff     <= `CVC_RST_WORD;
         enc_adj_vld_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         offs_est_ff    <= nxt_offs_est;
         enc_adj_vld_ff <= enc_sample_vld;
         if (enc_sample_vld)
            enc_adj_ff <= 16'(enc_sample + offs_est_ff);
      end
   end

   // =============================================
   // status flags and interrupt
   // the adm input write services the encoder adm-needed flag
   wire [3:0]     set_v   = {core_evt.enc_pcm, core_evt.enc_adm,
                             core_evt.dec_pcm, core_evt.dec_adm};
   wire [3:0]     clr_v   = (addr_vld ? svc_mask(rx_byte) : 4'b0000)
                            | (wr_admt ? 4'b0100 : 4'b0000);
   // set wins over a service clear in the same cycle
   wire [3:0]     nxt_flags = (flags_ff & ~clr_v) | set_v;
   wire [3:0]     en_data = {irq_en_ff[`CVC_ST_ENC_PCM], irq_en_ff[`CVC_ST_ENC_ADM],
                             irq_en_ff[`CVC_ST_DEC_PCM], irq_en_ff[`CVC_ST_DEC_ADM]};
   wire           vad_chg = ((enc_vad ^ enc_vad_ff) && irq_en_ff[`CVC_ST_ENC_VAD])
                            || ((dec_vad ^ dec_vad_ff) && irq_en_ff[`CVC_ST_DEC_VAD]);
   wire           irq_evt = (|(set_v & en_data)) || vad_chg;
   wire           nxt_pend = irq_evt || (irq_pend_ff && !rd_stat);

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         flags_ff    <= 4'h0;
         enc_vad_ff  <= 1'b0;
         dec_vad_ff  <= 1'b0;
         irq_pend_ff <= 1'b0;
         irq_n_ff    <= 1'b1;
      end
      else if (clk_en)
      begin
         flags_ff    <= nxt_flags;
         enc_vad_ff  <= enc_vad;
         dec_vad_ff  <= dec_vad;
         irq_pend_ff <= nxt_pend;
         irq_n_ff    <= ~nxt_pend;
      end
   end
endmodule

/* File: rtl/cvc_sbus.sv */
// serial control port: pin synchronisers, byte shifter, reply shifter
// assumes the host serial clock is far slower than sys_clk (8 cycles or more per period)
module cvc_sbus
   import cvc_pkg::*;
(
   input  wire logic        sys_clk,     // system clock
   input  wire logic        sys_rst,     // async reset, high
   input  wire logic        clk_en,      // freezes state when low
   input  wire logic        csn_n_pin,   // chip select pin, low active
   input  wire logic        sclk_pin,    // host serial clock pin
   input  wire logic        din_pin,     // command/data pin
   input  wire logic        tx_load,     // load reply word
   input  wire logic [15:0] tx_word,     // reply word, msb sent first
   output logic             rx_vld_ff,   // byte received pulse
   output logic [7:0]       rx_byte_ff,  // received byte
   output logic [1:0]       rx_idx_ff,   // byte index in transfer
   output logic             act_ff,      // transfer in progress
   output logic             dout_ff,     // reply pin level
   output logic             dout_oe_ff   // reply pin enable
);
   // =============================================
   // synchronisers
   logic [1:0]    csn_s_ff, din_s_ff;
   logic [2:0]    sclk_s_ff;
   cvc_sb_state_t st_ff;
   logic [2:0]    bit_ff;
   logic [1:0]    cnt_ff;
   logic [7:0]    sh_ff;
   logic [15:0]   tx_ff;
   logic          rise_seen_ff;
   wire           sel  = ~csn_s_ff[1];
   wire           rise = sclk_s_ff[1] & ~sclk_s_ff[2];
   wire           fall = ~sclk_s_ff[1] & sclk_s_ff[2];
   wire           last = (bit_ff == `CVC_BITS_BYTE);
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         csn_s_ff  <= 2'b11;
         sclk_s_ff <= 3'b000;
         din_s_ff  <= 2'b00;
      end
      else if (clk_en)
      begin
         csn_s_ff  <= {csn_s_ff[0], csn_n_pin};
         sclk_s_ff <= {sclk_s_ff[1:0], sclk_pin};
         din_s_ff  <= {din_s_ff[0], din_pin};
      end
   end
   // =============================================
   // receive shifter, msb first, sampled on rising serial clock
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_ff      <= SB_IDLE;
         bit_ff     <= 3'h0;
         cnt_ff     <= 2'h0;
         sh_ff      <= `CVC_RST_BYTE;
         rx_vld_ff  <= 1'b0;
         rx_byte_ff <= `CVC_RST_BYTE;
         rx_idx_ff  <= 2'h0;
         act_ff     <= 1'b0;
      end
      else if (clk_en)
      begin
         rx_vld_ff <= 1'b0;
         act_ff    <= sel;
         case (st_ff)
            SB_IDLE:
            begin
               bit_ff <= 3'h0;
               cnt_ff <= 2'h0;
               if (sel)
                  st_ff <= SB_SHIFT;
            end
            SB_SHIFT:
            begin
               if (!sel)
                  st_ff <= SB_IDLE;
               else if (rise)
               begin
                  sh_ff  <= {sh_ff[6:0], din_s_ff[1]};
                  bit_ff <= bit_ff + 3'h1;
                  if (last)
                  begin
                     rx_vld_ff  <= 1'b1;
                     rx_byte_ff <= {sh_ff[6:0], din_s_ff[1]};
                     rx_idx_ff  <= cnt_ff;
                     // saturate: extra bytes all report the last index
                     if (cnt_ff != 2'h3)
                        cnt_ff <= cnt_ff + 2'h1;
                  end
               end
            end
            default: st_ff <= SB_IDLE;
         endcase
      end
   end
   // =============================================
   // reply shifter: changes on falling edge so host samples a settled level
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_ff        <= `CVC_RST_WORD;
         dout_ff      <= 1'b0;
         dout_oe_ff   <= 1'b0;
         rise_seen_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!sel)
         begin
            dout_ff    <= 1'b0;
            dout_oe_ff <= 1'b0;
         end
         else if (tx_load)
         begin
            tx_ff        <= tx_word;
            dout_ff      <= tx_word[15];
            dout_oe_ff   <= 1'b1;
            rise_seen_ff <= 1'b0;
         end
         else if (rise)
            rise_seen_ff <= 1'b1;
         // the fall right after the address byte must not shift
         else if (fall && rise_seen_ff)
         begin
            tx_ff        <= {tx_ff[14:0], 1'b0};
            dout_ff      <= tx_ff[14];
            rise_seen_ff <= 1'b0;
         end
      end
   end
endmodule

/* File: testbench/cvc_host_model.sv */
// host side of the serial control port
// assumes a 40 MHz sys_clk; the serial clock has an 8-cycle period
module cvc_host_model
(
   input  wire logic sys_clk,    // clock
   output logic      sbus_csn_n, // select
   output logic      sbus_sclk,  // still between frames
   output logic      sbus_din,   // command/data
   input  wire logic sbus_line   // reply line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      sbus_csn_n = 1'b1;
      sbus_sclk = 1'b0;
      sbus_din = 1'b0;
   end
   // ==========================
   // address byte then n bytes, msb first; low phase is 5 cycles so the
   // reply has settled before the rise that samples it
   task automatic xfer(input logic [7:0] a, input int n, input logic [15:0] w,
                       output logic [15:0] r);
      logic [23:0] v;
      v = (n == 2) ? {a, w} : {a, w[7:0], 8'h00};
      r = 16'h0000;
      @(posedge sys_clk);
      sbus_csn_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      for (int i = 0; i < 8 + 8 * n; i++)
      begin
         sbus_din <= v[23 - i];
         repeat (2) @(posedge sys_clk);
         sbus_sclk <= 1'b1;
         r = (i >= 8) ? {r[14:0], sbus_line} : r;
         repeat (3) @(posedge sys_clk);
         sbus_sclk <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
      repeat (4) @(posedge sys_clk);
      sbus_csn_n <= 1'b1;
      sbus_din <= ~sbus_din;
      repeat (4) @(posedge sys_clk);
   endtask
endmodule

/* File: testbench/cvc_regs_checker.sv */
// assertions on the ports of the codec register bank
// assumes a bind to cvc_regs with clk_en held high
module cvc_regs_checker
   import cvc_pkg::*;
(
   input wire logic        sys_clk,        // clock
   input wire logic        sys_rst,        // reset
   input wire logic        sbus_csn_n,     // select
   input wire logic        sbus_dout_oe,   // reply enable
   input wire logic        irq_n_ff,       // irq
   input wire logic        enc_vad,        // voice
   input wire logic        dec_vad,        // voice
   input cvc_evt_t         core_evt,       // events
   input wire logic        dec_adm_mode,   // adm decode
   input wire logic        enc_sample_vld, // strobe
   input wire logic        enc_adj_vld_ff, // strobe
   input cvc_est_cfg_t     est_cfg_ff,     // config
   input wire logic [15:0] vad_thr_ff,     // threshold
   input wire logic        dac_load_ff     // pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ==========================
   // assertions
   adj_strobe_a: assert property (enc_sample_vld |=> enc_adj_vld_ff)
      else $error("adjusted strobe missing");
   first_order_a: assert property (est_cfg_ff.first_order |->
      est_cfg_ff.loss_shift == 2'h0 && est_cfg_ff.zero_sel == 2'h0)
      else $error("first order config wrong");
   half_zero_a: assert property (est_cfg_ff.half_zero_en |-> $past(dec_adm_mode))
      else $error("half rate zero outside adm decode");
   thr_range_a: assert property (vad_thr_ff[15] == 1'b0)
      else $error("threshold above range");
   irq_cause_a: assert property ($fell(irq_n_ff) |-> $past(|core_evt) ||
      $past(enc_vad) != $past(enc_vad, 2) || $past(dec_vad) != $past(dec_vad, 2))
      else $error("irq without cause");
   irq_hold_a: assert property (sbus_csn_n [*8] ##0 !irq_n_ff |=> !irq_n_ff)
      else $error("irq dropped without status read");
   dac_pulse_a: assert property (dac_load_ff |=> !dac_load_ff)
      else $error("dac load longer than a cycle");
   oe_idle_a: assert property (sbus_csn_n [*5] |-> !sbus_dout_oe)
      else $error("reply driven while deselected");
   cover property ($fell(irq_n_ff));
   cover property (dac_load_ff);
   cover property (est_cfg_ff.half_zero_en);
endmodule

/* File: testbench/cvc_regs_tb_top.sv */
// self-checking bench for the codec register bank
// assumes the design, host model and checker are compiled first
module cvc_regs_tb_top
   import cvc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic enc_vad, dec_vad, dec_adm_mode, enc_sample_vld, rd_vld;
   logic line_hold = 1'b0;
   logic sbus_csn_n, sbus_sclk, sbus_din, sbus_dout, sbus_dout_oe, irq_n_ff;
   logic enc_adj_vld_ff, dac_load_ff, adm_test_vld_ff;
   logic [15:0] dec_vad_level, enc_sample, rd_val, enc_adj_ff, vad_thr_ff, dac_direct_ff;
   logic [7:0] adm_test_ff;
   cvc_evt_t core_evt;
   cvc_est_cfg_t est_cfg_ff;
   logic [15:0] exp_q[$];
   logic [7:0] st [4] = '{8'h20, 8'h10, 8'h02, 8'h01};
   logic [7:0] sv [4] = '{8'he6, 8'hea, 8'hd6, 8'hda};
   logic [1:0] vt [3] = '{2'b10, 2'b11, 2'b01};
   int fails = 0;
   int comparisons = 0;
   always #12.5 sys_clk = ~sys_clk;
   // released reply line shows the inverse of its last level
   wire sbus_line = sbus_dout_oe ? sbus_dout : ~line_hold;
   always @(posedge sys_clk)
      line_hold <= sbus_dout_oe ? sbus_dout : line_hold;
   cvc_host_model host_inst (.sys_clk, .sbus_csn_n, .sbus_sclk, .sbus_din, .sbus_line);
   cvc_regs cvc_regs_inst (.sys_clk, .sys_rst, .clk_en(1'b1), .sbus_csn_n, .sbus_sclk,
      .sbus_din, .sbus_dout, .sbus_dout_oe, .irq_n_ff, .enc_vad, .dec_vad, .dec_vad_level,
      .core_evt, .dec_adm_mode, .enc_sample, .enc_sample_vld, .enc_adj_ff, .enc_adj_vld_ff,
      .est_cfg_ff, .vad_thr_ff, .dac_direct_ff, .dac_load_ff, .adm_test_ff, .adm_test_vld_ff);
   // ==========================
   // comparison and report
   task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic pop_chk(input logic [15:0] g);
      if (exp_q.size() == 0)
         chk_word(g, ~g);
      else
         chk_word(g, exp_q.pop_front());
   endtask
   task automatic wrap_up();
      fails += exp_q.size();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      if (rd_vld === 1'b1)
         pop_chk(rd_val);
      if (dac_load_ff === 1'b1)
         pop_chk(dac_direct_ff);
      if (adm_test_vld_ff === 1'b1)
         pop_chk({8'h00, adm_test_ff});
      if (enc_adj_vld_ff === 1'b1)
         pop_chk(enc_adj_ff);
   end
   // ==========================
   // bus and stimulus tasks
   task automatic wr(input logic [7:0] a, input int n, input logic [15:0] w);
      logic [15:0] r;
      host_inst.xfer(a, n, w, r);
   endtask
   task automatic rd(input logic [7:0] a, input int n, input logic [15:0] e);
      logic [15:0] r;
      exp_q.push_back(e);
      host_inst.xfer(a, n, 16'h0000, r);
      rd_val <= r;
      rd_vld <= 1'b1;
      @(posedge sys_clk);
      rd_vld <= 1'b0;
   endtask
   task automatic smp(input logic [15:0] s, input logic [15:0] e);
      exp_q.push_back(e);
      enc_sample <= s;
      enc_sample_vld <= 1'b1;
      @(posedge sys_clk);
      enc_sample_vld <= 1'b0;
      @(posedge sys_clk);
   endtask
   initial
   begin
      logic [15:0] v, s;
      logic m;
      void'($urandom(32'h153b_74c3));
      {enc_vad, dec_vad, dec_adm_mode, enc_sample_vld, rd_vld} = 5'h00;
      core_evt = '0;
      enc_sample = 16'h0000;
      rd_val = 16'h0000;
      dec_vad_level = -16'($urandom_range(32768));
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(8'h80, 1, 16'h0000);
      rd(8'hd4, 2, dec_vad_level);
      rd(8'h55, 2, 16'h0000);
      v = 16'($urandom);
      wr(8'he2, 2, v | 16'h8000);
      chk_word(vad_thr_ff, v & 16'h7fff);
      for (int i = 0; i < 32; i++)
      begin
         m = 1'($urandom);
         dec_adm_mode <= m;
         wr(8'he0, 2, {11'h000, i[4:1], i[0] & m});
         chk_word({10'h000, est_cfg_ff}, {10'h000, i[4:3] == 2'h0, i[4:3],
            (i[4:3] == 2'h0) ? 2'h0 : i[2:1], i[0] & m});
      end
      v = 16'h0002 + 16'($urandom_range(14));
      wr(8'he3, 2, v);
      rd(8'he5, 2, v);
      s = 16'($urandom);
      smp(s, s + v);
      wr(8'he0, 2, 16'h0100);
      wr(8'he3, 2, 16'h0000);
      smp(s, s + v);
      rd(8'he5, 2, v);
      wr(8'he0, 2, 16'h0000);
      wr(8'he3, 2, 16'h0000);
      smp(s, s);
      v = 16'($urandom);
      exp_q.push_back(v);
      wr(8'he7, 2, v);
      exp_q.push_back({8'h00, v[7:0]});
      wr(8'he8, 1, v);
      wr(8'h81, 1, 16'h0077);
      for (int k = 0; k < 4; k++)
      begin
         core_evt <= cvc_evt_t'(4'h8 >> k);
         @(posedge sys_clk);
         core_evt <= '0;
         @(posedge sys_clk);
         chk_word({15'h0000, irq_n_ff}, 16'h0000);
         rd(8'h80, 1, {8'h00, st[k]});
         chk_word({15'h0000, irq_n_ff}, 16'h0001);
         rd(sv[k], 2, 16'h0000);
         rd(8'h80, 1, 16'h0000);
      end
      // a completed adm input write services the encoder adm flag
      core_evt <= cvc_evt_t'(4'h4);
      @(posedge sys_clk);
      core_evt <= '0;
      rd(8'h80, 1, 16'h0010);
      exp_q.push_back(16'h00a5);
      wr(8'he8, 1, 16'h00a5);
      rd(8'h80, 1, 16'h0000);
      for (int k = 0; k < 3; k++)
      begin
         {enc_vad, dec_vad} <= vt[k];
         repeat (2) @(posedge sys_clk);
         chk_word({15'h0000, irq_n_ff}, 16'h0000);
         rd(8'h80, 1, {9'h000, vt[k][1], 3'h0, vt[k][0], 2'h0});
      end
      wr(8'h81, 1, 16'h0000);
      core_evt <= cvc_evt_t'(4'h8);
      @(posedge sys_clk);
      core_evt <= '0;
      repeat (3) @(posedge sys_clk);
      chk_word({15'h0000, irq_n_ff}, 16'h0001);
      rd(8'h80, 1, 16'h0024);
      for (int t = 0; t < 20 && exp_q.size() > 0; t++)
         @(posedge sys_clk);
      wrap_up();
   end
   initial
   begin
      repeat (100000) @(posedge sys_clk);
      fails++;
      wrap_up();
   end
endmodule
bind cvc_regs cvc_regs_checker cvc_regs_checker_inst (.sys_clk, .sys_rst, .sbus_csn_n,
   .sbus_dout_oe, .irq_n_ff, .enc_vad, .dec_vad, .core_evt, .dec_adm_mode, .enc_sample_vld,
   .enc_adj_vld_ff, .est_cfg_ff, .vad_thr_ff, .dac_load_ff);
